// File: hdl/scp_pkg.sv
package scp_pkg;

    // -------------------------------------------------
    // frame layout
    // -------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int OP_LSB    = 0;
    localparam int OP_W      = 2;
    localparam int CKT_LSB   = 2;
    localparam int CKT_W     = 2;
    localparam int BANK_LSB  = 4;
    localparam int BANK_W    = 2;

    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] IDX_OP    = 2'h0;
    localparam logic [1:0] IDX_ADDR  = 2'h1;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // -------------------------------------------------
    // reset values
    // -------------------------------------------------
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] SEL_RST  = 2'h0;
    localparam logic [2:0] SYNC_RST = 3'h0;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_WDATA,
        ST_RESP,
        ST_SKIP
    } scp_state_t;

endpackage : scp_pkg

// File: hdl/scp_toggle_if.sv
`timescale 1ns/1ns
`default_nettype none

interface scp_toggle_if;
    logic tog;
    logic pulse;
    modport src (output tog, input pulse);
    modport dst (input tog, output pulse);
endinterface : scp_toggle_if

`default_nettype wire

// File: hdl/scp_toggle_sync.sv
`timescale 1ns/1ns
`default_nettype none

module scp_toggle_sync (
    input  wire logic   clk,
    input  wire logic   rstn,
    scp_toggle_if.dst   port
);

    // -------------------------------------------------
    // two-flop sync plus edge stage
    // -------------------------------------------------
    logic [2:0] sync_q;
    logic [2:0] sync_d;

    always_comb begin
        sync_d = {sync_q[1:0], port.tog};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_q <= scp_pkg::SYNC_RST;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign port.pulse = sync_q[2] ^ sync_q[1];

endmodule : scp_toggle_sync

`default_nettype wire

// File: hdl/scp_slave.sv
// Behaviour
// - serial logic runs on serial clock only
// - each byte shifts least significant bit first
// - multibyte fields go low byte first
// - strap open normal, grounded byte-by-byte
// - normal: select on rise, data on fall
// - byte mode: select and data on rise
// - partial byte under select aborts operation
// - after abort next select starts command
// - serial clock may gap while deselected
// - clock pause keeps state, resumes next edge
// - drive response whenever selected in response
// - write has no reply, read returns data
// - multibyte access walks ascending addresses
// - response phase ignores serial input
// - byte mode read takes N plus three
// - every location moves as one byte
// - bank selection travels in command frame
// - output enabled only while driving response
`timescale 1ns/1ns
`default_nettype none

module scp_slave (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       serial_ctrl_clock,
    input  wire logic       ctrlSelN,
    input  wire logic       serial_ctrl_in,
    input  wire logic       port_mode_strap,
    output logic            serialOut,
    output logic            serialOutEn,
    output logic            memWrEn,
    output logic            memRdEn,
    output logic [7:0]      memAddr,
    output logic [1:0]      memBank,
    output logic [1:0]      memCkt,
    output logic [7:0]      memWrData,
    input  wire logic [7:0] memRdData
);

    // -------------------------------------------------
    // link: rising edge samples
    // -------------------------------------------------
    logic       csRise_q;
    logic       csRise_d;
    logic       diRise_q;
    logic       diRise_d;
    logic [1:0] strap_q;
    logic [1:0] strap_d;
    logic       modeByte;

    always_comb begin
        csRise_d = ctrlSelN;
        diRise_d = serial_ctrl_in;
        strap_d  = {strap_q[0], port_mode_strap};
    end

    always_ff @(posedge serial_ctrl_clock or negedge rstn) begin
        if (!rstn) begin
            csRise_q <= 1'b1;
            diRise_q <= 1'b0;
            strap_q  <= 2'h3;
        end else begin
            csRise_q <= csRise_d;
            diRise_q <= diRise_d;
            strap_q  <= strap_d;
        end
    end

    assign modeByte = !strap_q[1];

    // -------------------------------------------------
    // link: frame engine on falling edge
    // -------------------------------------------------
    scp_pkg::scp_state_t state_q;
    scp_pkg::scp_state_t state_d;
    logic [2:0] bitCnt_q;
    logic [2:0] bitCnt_d;
    logic [1:0] byteIdx_q;
    logic [1:0] byteIdx_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [1:0] op_q;
    logic [1:0] op_d;
    logic [1:0] ckt_q;
    logic [1:0] ckt_d;
    logic [1:0] bank_q;
    logic [1:0] bank_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic [7:0] left_q;
    logic [7:0] left_d;
    logic [7:0] wrAddr_q;
    logic [7:0] wrAddr_d;
    logic [7:0] wrData_q;
    logic [7:0] wrData_d;
    logic       wrTog_q;
    logic       wrTog_d;
    logic [7:0] rdAddr_q;
    logic [7:0] rdAddr_d;
    logic       rdTog_q;
    logic       rdTog_d;
    logic [7:0] txShift_q;
    logic [7:0] txShift_d;
    logic       doOut_q;
    logic       doOut_d;
    logic       doOe_q;
    logic       doOe_d;
    logic       rxBit;
    logic [7:0] rxByte;
    logic [7:0] rdBuf_q;

    always_comb begin
        state_d   = state_q;
        bitCnt_d  = bitCnt_q;
        byteIdx_d = byteIdx_q;
        shift_d   = shift_q;
        op_d      = op_q;
        ckt_d     = ckt_q;
        bank_d    = bank_q;
        addr_d    = addr_q;
        left_d    = left_q;
        wrAddr_d  = wrAddr_q;
        wrData_d  = wrData_q;
        wrTog_d   = wrTog_q;
        rdAddr_d  = rdAddr_q;
        rdTog_d   = rdTog_q;
        txShift_d = txShift_q;
        doOut_d   = doOut_q;
        doOe_d    = 1'b0;
        rxBit     = modeByte ? diRise_q : serial_ctrl_in;
        rxByte    = {rxBit, shift_q[7:1]};
        if (csRise_q) begin
            // byte boundary check on deselect
            if (bitCnt_q != scp_pkg::BIT_FIRST) begin
                state_d   = scp_pkg::ST_CMD;
                byteIdx_d = scp_pkg::IDX_OP;
            end else if (state_q == scp_pkg::ST_SKIP) begin
                state_d = scp_pkg::ST_CMD;
            end
            bitCnt_d = scp_pkg::BIT_FIRST;
        end else begin
            // no timeout: a stopped clock just holds state
            bitCnt_d = bitCnt_q + 3'h1;
            shift_d  = rxByte;
            doOe_d   = (state_q == scp_pkg::ST_RESP);
            unique case (state_q)
                scp_pkg::ST_CMD: begin
                    if (bitCnt_q == scp_pkg::BIT_LAST) begin
                        unique case (byteIdx_q)
                            scp_pkg::IDX_OP: begin
                                op_d      = rxByte[scp_pkg::OP_LSB +: scp_pkg::OP_W];
                                ckt_d     = rxByte[scp_pkg::CKT_LSB +: scp_pkg::CKT_W];
                                bank_d    = rxByte[scp_pkg::BANK_LSB +: scp_pkg::BANK_W];
                                byteIdx_d = scp_pkg::IDX_ADDR;
                            end
                            scp_pkg::IDX_ADDR: begin
                                addr_d    = rxByte;
                                byteIdx_d = 2'h2;
                            end
                            default: begin
                                left_d    = rxByte;
                                byteIdx_d = scp_pkg::IDX_OP;
                                if (rxByte == scp_pkg::BYTE_RST) begin
                                    state_d = scp_pkg::ST_CMD;
                                end else if (op_q == scp_pkg::OP_WRITE) begin
                                    state_d = scp_pkg::ST_WDATA;
                                end else if (op_q == scp_pkg::OP_READ) begin
                                    state_d  = scp_pkg::ST_RESP;
                                    rdAddr_d = addr_q;
                                    rdTog_d  = !rdTog_q;
                                end else begin
                                    state_d = scp_pkg::ST_SKIP;
                                end
                            end
                        endcase
                    end
                end
                scp_pkg::ST_WDATA: begin
                    if (bitCnt_q == scp_pkg::BIT_LAST) begin
                        wrAddr_d = addr_q;
                        wrData_d = rxByte;
                        wrTog_d  = !wrTog_q;
                        addr_d   = addr_q + 8'h01;
                        left_d   = left_q - 8'h01;
                        if (left_q == 8'h01) begin
                            state_d = scp_pkg::ST_CMD;
                        end
                    end
                end
                scp_pkg::ST_RESP: begin
                    // serial input is not decoded here
                    if (bitCnt_q == scp_pkg::BIT_FIRST) begin
                        txShift_d = rdBuf_q;
                        doOut_d   = rdBuf_q[0];
                        if (left_q != 8'h01) begin
                            rdAddr_d = rdAddr_q + 8'h01;
                            rdTog_d  = !rdTog_q;
                        end
                    end else begin
                        doOut_d = txShift_q[bitCnt_q];
                    end
                    if (bitCnt_q == scp_pkg::BIT_LAST) begin
                        left_d = left_q - 8'h01;
                        if (left_q == 8'h01) begin
                            state_d = scp_pkg::ST_CMD;
                        end
                    end
                end
                scp_pkg::ST_SKIP: begin
                end
            endcase
        end
    end

    always_ff @(negedge serial_ctrl_clock or negedge rstn) begin
        if (!rstn) begin
            state_q   <= scp_pkg::ST_CMD;
            bitCnt_q  <= scp_pkg::BIT_FIRST;
            byteIdx_q <= scp_pkg::IDX_OP;
            shift_q   <= scp_pkg::BYTE_RST;
            op_q      <= scp_pkg::SEL_RST;
            ckt_q     <= scp_pkg::SEL_RST;
            bank_q    <= scp_pkg::SEL_RST;
            addr_q    <= scp_pkg::BYTE_RST;
            left_q    <= scp_pkg::BYTE_RST;
            wrAddr_q  <= scp_pkg::BYTE_RST;
            wrData_q  <= scp_pkg::BYTE_RST;
            wrTog_q   <= 1'b0;
            rdAddr_q  <= scp_pkg::BYTE_RST;
            rdTog_q   <= 1'b0;
            txShift_q <= scp_pkg::BYTE_RST;
            doOut_q   <= 1'b0;
            doOe_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            bitCnt_q  <= bitCnt_d;
            byteIdx_q <= byteIdx_d;
            shift_q   <= shift_d;
            op_q      <= op_d;
            ckt_q     <= ckt_d;
            bank_q    <= bank_d;
            addr_q    <= addr_d;
            left_q    <= left_d;
            wrAddr_q  <= wrAddr_d;
            wrData_q  <= wrData_d;
            wrTog_q   <= wrTog_d;
            rdAddr_q  <= rdAddr_d;
            rdTog_q   <= rdTog_d;
            txShift_q <= txShift_d;
            doOut_q   <= doOut_d;
            doOe_q    <= doOe_d;
        end
    end

    assign serialOut   = doOut_q;
    assign serialOutEn = doOe_q;

    // -------------------------------------------------
    // crossing to system clock
    // -------------------------------------------------
    scp_toggle_if wrIf ();
    scp_toggle_if rdIf ();

    assign wrIf.tog = wrTog_q;
    assign rdIf.tog = rdTog_q;

    scp_toggle_sync uWrSync (
        .clk  (clk),
        .rstn (rstn),
        .port (wrIf)
    );

    scp_toggle_sync uRdSync (
        .clk  (clk),
        .rstn (rstn),
        .port (rdIf)
    );

    // -------------------------------------------------
    // memory side
    // -------------------------------------------------
    logic       memWrEn_q;
    logic       memWrEn_d;
    logic       memRdEn_q;
    logic       memRdEn_d;
    logic [7:0] memAddr_q;
    logic [7:0] memAddr_d;
    logic [1:0] memBank_q;
    logic [1:0] memBank_d;
    logic [1:0] memCkt_q;
    logic [1:0] memCkt_d;
    logic [7:0] memWrData_q;
    logic [7:0] memWrData_d;
    logic [7:0] rdBuf_d;
    logic       rdTake_q;
    logic       rdTake_d;

    always_comb begin
        memWrEn_d   = wrIf.pulse;
        memRdEn_d   = rdIf.pulse;
        rdTake_d    = memRdEn_q;
        memAddr_d   = memAddr_q;
        memBank_d   = memBank_q;
        memCkt_d    = memCkt_q;
        memWrData_d = memWrData_q;
        rdBuf_d     = rdTake_q ? memRdData : rdBuf_q;
        if (wrIf.pulse) begin
            memAddr_d   = wrAddr_q;
            memWrData_d = wrData_q;
            memBank_d   = bank_q;
            memCkt_d    = ckt_q;
        end else if (rdIf.pulse) begin
            memAddr_d = rdAddr_q;
            memBank_d = bank_q;
            memCkt_d  = ckt_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memWrEn_q   <= 1'b0;
            memRdEn_q   <= 1'b0;
            memAddr_q   <= scp_pkg::BYTE_RST;
            memBank_q   <= scp_pkg::SEL_RST;
            memCkt_q    <= scp_pkg::SEL_RST;
            memWrData_q <= scp_pkg::BYTE_RST;
            rdBuf_q     <= scp_pkg::BYTE_RST;
            rdTake_q    <= 1'b0;
        end else begin
            memWrEn_q   <= memWrEn_d;
            memRdEn_q   <= memRdEn_d;
            memAddr_q   <= memAddr_d;
            memBank_q   <= memBank_d;
            memCkt_q    <= memCkt_d;
            memWrData_q <= memWrData_d;
            rdBuf_q     <= rdBuf_d;
            rdTake_q    <= rdTake_d;
        end
    end

    assign memWrEn   = memWrEn_q;
    assign memRdEn   = memRdEn_q;
    assign memAddr   = memAddr_q;
    assign memBank   = memBank_q;
    assign memCkt    = memCkt_q;
    assign memWrData = memWrData_q;

    // -------------------------------------------------
    // checks
    // -------------------------------------------------
    property p_wr_commit;
        @(posedge clk) disable iff (!rstn)
        wrIf.pulse |=> memWrEn_q && memWrData_q == wrData_q && memAddr_q == wrAddr_q ##1 !memWrEn_q;
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("write not committed");

    property p_rd_fetch;
        @(posedge clk) disable iff (!rstn)
        rdIf.pulse |=> memRdEn_q && memAddr_q == rdAddr_q ##2 rdBuf_q == $past(memRdData);
    endproperty
    a_rd_fetch: assert property (p_rd_fetch) else $error("read data not buffered");

    property p_abort;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        (csRise_q && bitCnt_q != 3'h0) |=> state_q == scp_pkg::ST_CMD && byteIdx_q == 2'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("partial byte not aborted");

    property p_bit_count;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        !csRise_q |=> bitCnt_q == 3'($past(bitCnt_q) + 3'h1);
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bit count slipped");

    property p_lsb_first;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        (!csRise_q && !modeByte) |=> shift_q[7] == $past(serial_ctrl_in);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("normal data not shifted in");

    property p_byte_mode;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        (!csRise_q && modeByte) |=> shift_q[7] == $past(diRise_q);
    endproperty
    a_byte_mode: assert property (p_byte_mode) else $error("byte mode sample wrong");

    property p_resp_quiet;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        state_q == scp_pkg::ST_RESP |=> wrTog_q == $past(wrTog_q);
    endproperty
    a_resp_quiet: assert property (p_resp_quiet) else $error("write during response");

    property p_oe;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        doOe_q |-> $past(state_q) == scp_pkg::ST_RESP && !$past(csRise_q);
    endproperty
    a_oe: assert property (p_oe) else $error("output driven outside response");

    property p_addr_inc;
        @(negedge serial_ctrl_clock) disable iff (!rstn)
        (state_q == scp_pkg::ST_WDATA && !csRise_q && bitCnt_q == 3'h7)
        |=> wrAddr_q == $past(addr_q) && addr_q == 8'($past(addr_q) + 8'h01);
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address not ascending");

endmodule : scp_slave

`default_nettype wire

// File: verif/scp_master_model.sv
`timescale 1ns/1ns
`default_nettype none

module scp_master_model (
    output var logic sck,
    output var logic selN,
    output var logic sdi,
    input  wire logic sdo,
    input  wire logic byteMode
);
    // ---------------------------------------------
    // serial master
    // ---------------------------------------------
    initial begin
        sck  = 1'b0;
        selN = 1'b1;
        sdi  = 1'b0;
    end

    // lines set before the rise, clock rests low
    task automatic pulse();
        #2;
        sck <= 1'b1;
        #3;
        sck <= 1'b0;
        #1;
    endtask : pulse

    task automatic bitOut(input logic d);
        selN <= 1'b0;
        sdi  <= d;
        pulse();
    endtask : bitOut

    // select seen high on one rise, then a frame gap
    task automatic deselect();
        selN <= 1'b1;
        sdi  <= ~sdi;
        pulse();
        #250;
    endtask : deselect

    task automatic byteEnd();
        if (byteMode) begin
            deselect();
        end else begin
            #200;
        end
    endtask : byteEnd

    task automatic putByte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            bitOut(b[i]);
        end
        byteEnd();
    endtask : putByte

    // input toggles while the answer is shifted out
    task automatic getByte(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            bitOut(i[0]);
            #2;
            b[i] = sdo;
        end
        byteEnd();
    endtask : getByte

    task automatic partial(input int n);
        for (int i = 0; i < n; i++) begin
            bitOut(1'b1);
        end
        deselect();
    endtask : partial

    task automatic command(input logic [1:0] op, input logic [1:0] ckt,
                           input logic [1:0] bank, input logic [7:0] addr,
                           input logic [7:0] len);
        putByte({2'h0, bank, ckt, op});
        putByte(addr);
        putByte(len);
    endtask : command

    task automatic endFrame();
        if (!byteMode) begin
            deselect();
        end
    endtask : endFrame
endmodule : scp_master_model

`default_nettype wire

// File: verif/serial_control_port_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none

module serial_control_port_slave_bench;
    // ---------------------------------------------
    // signals, memory model
    // ---------------------------------------------
    logic       clk;
    logic       rstn;
    logic       modeStrap;
    logic       sck;
    logic       selN;
    logic       sdi;
    wire        sdoWire;
    logic       serialOut;
    logic       serialOutEn;
    logic       memWrEn;
    logic       memRdEn;
    logic [7:0] memAddr;
    logic [1:0] memBank;
    logic [1:0] memCkt;
    logic [7:0] memWrData;
    logic [7:0] memRdData;
    logic [3:0] sideInfo;
    logic [7:0] mem [256];
    logic [7:0] rb [3];
    int         miscompares;
    int         check_count;
    int         wrCount;
    int         rdCount;
    int         enCount;
    int         selFalls;

    assign sdoWire = serialOutEn ? serialOut : 1'bz;

    scp_slave dut (
        .clk,
        .rstn,
        .serial_ctrl_clock(sck),
        .ctrlSelN(selN),
        .serial_ctrl_in(sdi),
        .port_mode_strap(modeStrap),
        .serialOut,
        .serialOutEn,
        .memWrEn,
        .memRdEn,
        .memAddr,
        .memBank,
        .memCkt,
        .memWrData,
        .memRdData
    );

    scp_master_model master (
        .sck,
        .selN,
        .sdi,
        .sdo(sdoWire),
        .byteMode(!modeStrap)
    );

    always #10 clk = ~clk;

    always @(posedge clk) begin
        if (memWrEn) begin
            mem[memAddr] <= memWrData;
            sideInfo     <= {memBank, memCkt};
            wrCount++;
        end
        if (memRdEn) begin
            memRdData <= mem[memAddr];
            rdCount++;
        end
        if (serialOutEn) begin
            enCount++;
        end
    end

    always @(negedge selN) begin
        selFalls++;
    end

    // ---------------------------------------------
    // checking and closing
    // ---------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic test_write_normal();
        logic [7:0] d [3] = '{8'ha5, 8'h3c, 8'h81};
        logic [7:0] a;
        enCount = 0;
        wrCount = 0;
        master.command(scp_pkg::OP_WRITE, 2'h1, 2'h2, 8'hfe, 8'h03);
        for (int i = 0; i < 3; i++) begin
            master.putByte(d[i]);
        end
        master.endFrame();
        for (int i = 0; i < 3; i++) begin
            a = 8'hfe + 8'(i);
            check("wr_data", mem[a], d[i]);
        end
        check("wr_count", wrCount, 3);
        check("wr_side", sideInfo, {2'h2, 2'h1});
        check("wr_reply", enCount, 0);
        $display("write_normal done");
    endtask : test_write_normal

    task automatic test_read_normal();
        logic [7:0] d [3] = '{8'hc3, 8'h5a, 8'he7};
        for (int i = 0; i < 3; i++) begin
            mem[16 + i] = d[i];
        end
        rdCount = 0;
        wrCount = 0;
        master.command(scp_pkg::OP_READ, 2'h0, 2'h0, 8'h10, 8'h03);
        master.endFrame();
        for (int i = 0; i < 3; i++) begin
            master.getByte(rb[i]);
        end
        master.endFrame();
        for (int i = 0; i < 3; i++) begin
            check("rd_data", rb[i], d[i]);
        end
        check("rd_count", rdCount, 3);
        check("rd_writes", wrCount, 0);
        check("out_enable", serialOutEn, 1'b0);
        $display("read_normal done");
    endtask : test_read_normal

    task automatic test_abort();
        wrCount = 0;
        master.partial(5);
        master.command(scp_pkg::OP_WRITE, 2'h0, 2'h0, 8'h20, 8'h02);
        master.putByte(8'h11);
        master.partial(3);
        master.command(2'h3, 2'h0, 2'h0, 8'h21, 8'h01);
        master.endFrame();
        master.command(scp_pkg::OP_WRITE, 2'h0, 2'h0, 8'h22, 8'h00);
        master.endFrame();
        master.command(scp_pkg::OP_WRITE, 2'h0, 2'h0, 8'h30, 8'h01);
        master.putByte(8'h77);
        master.endFrame();
        check("abort_kept", mem[8'h20], 8'h11);
        check("abort_drop", mem[8'h21], 8'h00);
        check("abort_next", mem[8'h30], 8'h77);
        check("abort_count", wrCount, 2);
        $display("abort done");
    endtask : test_abort

    task automatic test_byte_mode();
        logic [7:0] d [2] = '{8'h96, 8'h69};
        @(posedge clk);
        modeStrap <= 1'b0;
        @(posedge clk);
        repeat (3) master.pulse();
        wrCount = 0;
        rdCount = 0;
        master.command(scp_pkg::OP_WRITE, 2'h3, 2'h0, 8'h40, 8'h02);
        for (int i = 0; i < 2; i++) begin
            master.putByte(d[i]);
        end
        selFalls = 0;
        master.command(scp_pkg::OP_READ, 2'h3, 2'h0, 8'h40, 8'h02);
        for (int i = 0; i < 2; i++) begin
            master.getByte(rb[i]);
        end
        for (int i = 0; i < 2; i++) begin
            check("bm_data", rb[i], d[i]);
        end
        check("bm_frames", selFalls, 5);
        check("bm_writes", wrCount, 2);
        check("bm_reads", rdCount, 2);
        check("bm_side", sideInfo, {2'h0, 2'h3});
        @(posedge clk);
        modeStrap <= 1'b1;
        @(posedge clk);
        repeat (3) master.pulse();
        $display("byte_mode done");
    endtask : test_byte_mode

    initial begin
        clk       = 1'b0;
        rstn      = 1'b0;
        modeStrap = 1'b1;
        memRdData = 8'h00;
        sideInfo  = 4'h0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        repeat (3) master.pulse();
        test_write_normal();
        test_read_normal();
        test_abort();
        test_byte_mode();
        results();
    end

    initial begin
        #300000;
        miscompares++;
        results();
    end
endmodule : serial_control_port_slave_bench

`default_nettype wire
